// ---- rtl/monitor_fault_status_latch.sv ----
/*
 * Sticky fault-status registers of a hardware monitor, read over APB.
 * Assumes readings, limits, tach counts and diode faults arrive as
 * synchronous levels from the measurement engine on clock.
 */
// Implementation choice: the APB slave port.
// Notes on behaviour
// - A flag sets whenever its reading lies outside its limit window.
// - A set flag stays set until software reads its register.
// - A read clears the register once the fault has gone.
// - Both status registers are read only; writes change nothing.
// - Several flags may be set together and reported in one read.
// - Bits 0-3 of register one: supply at or below low, or above high.
// - Bit 4 of register one: diode one temperature outside zone one window.
// - Bit 5 of register one: internal temperature outside zone two window.
// - Bit 6 of register one: diode two temperature outside zone three window.
// - Bit 7 of register one shows any set bit of register two.
// - Bit 0 of register two: 12V strictly below low or above high.
// - Bits 2-5 of register two: tach count above its 16-bit minimum.
// - Bits 6 and 7 of register two: open or short on diode one, two.
// - A diode fault also sets bit 4 or bit 6 of register one.
// - Temperature comparisons are signed eight-bit two's complement.
`timescale 1ns/100ps
`default_nettype none
module monitor_fault_status_latch (
	input  wire logic        clock,
	input  wire logic        nrst,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Supply readings and limits
	input  wire logic [7:0]  supply_2v5_level,
	input  wire logic [7:0]  supply_2v5_low,
	input  wire logic [7:0]  supply_2v5_high,
	input  wire logic [7:0]  processor_core_supply,
	input  wire logic [7:0]  processor_core_low,
	input  wire logic [7:0]  processor_core_high,
	input  wire logic [7:0]  supply_3v3_level,
	input  wire logic [7:0]  supply_3v3_low,
	input  wire logic [7:0]  supply_3v3_high,
	input  wire logic [7:0]  supply_5v_level,
	input  wire logic [7:0]  supply_5v_low,
	input  wire logic [7:0]  supply_5v_high,
	input  wire logic [7:0]  supply_12v_level,
	input  wire logic [7:0]  supply_12v_low,
	input  wire logic [7:0]  supply_12v_high,
	// Temperatures and zone limits, two's complement
	input  wire logic [7:0]  diode_one_temp,
	input  wire logic [7:0]  internal_temp,
	input  wire logic [7:0]  diode_two_temp,
	input  wire logic [7:0]  zone_one_low,
	input  wire logic [7:0]  zone_one_high,
	input  wire logic [7:0]  zone_two_low,
	input  wire logic [7:0]  zone_two_high,
	input  wire logic [7:0]  zone_three_low,
	input  wire logic [7:0]  zone_three_high,
	// Remote diode open/short detection
	input  wire logic        diode_one_open_short,
	input  wire logic        diode_two_open_short,
	// Tach counts and minimum values
	input  wire logic [15:0] speed_count_one,
	input  wire logic [15:0] speed_count_two,
	input  wire logic [15:0] speed_count_three,
	input  wire logic [15:0] speed_count_four,
	input  wire logic [15:0] stall_limit_one,
	input  wire logic [15:0] stall_limit_two,
	input  wire logic [15:0] stall_limit_three,
	input  wire logic [15:0] stall_limit_four
);
	// ----------------------------------------------------------------
	// Fault conditions
	// ----------------------------------------------------------------
	logic [fault_status_pkg::VOLT_CHANS-1:0] volt_out;
	logic [fault_status_pkg::COOLERS-1:0]    stall_out;
	logic [7:0]  volt_lvl [fault_status_pkg::VOLT_CHANS];
	logic [7:0]  volt_lo  [fault_status_pkg::VOLT_CHANS];
	logic [7:0]  volt_hi  [fault_status_pkg::VOLT_CHANS];
	logic [15:0] tach_cnt [fault_status_pkg::COOLERS];
	logic [15:0] tach_min [fault_status_pkg::COOLERS];
	logic        supply_2v5_flag;
	logic        supply_12v_flag;
	logic        zone_one_out;
	logic        zone_two_out;
	logic        zone_three_out;
	logic        zone_one_limit_flag;
	logic        zone_two_limit_flag;
	logic        zone_three_limit_flag;
	logic        diode_one_fault_flag;
	logic        diode_two_fault_flag;
	logic        cooler_one_stall_flag;
	logic        cooler_two_stall_flag;
	logic        cooler_three_stall_flag;
	logic        cooler_four_stall_flag;
	logic [fault_status_pkg::STS1_FLAGS-1:0] cond1;
	logic [fault_status_pkg::STS2_FLAGS-1:0] cond2;

	// Channel order matches bit order of register one
	assign volt_lvl = '{supply_2v5_level, processor_core_supply,
	                    supply_3v3_level, supply_5v_level};
	assign volt_lo  = '{supply_2v5_low, processor_core_low,
	                    supply_3v3_low, supply_5v_low};
	assign volt_hi  = '{supply_2v5_high, processor_core_high,
	                    supply_3v3_high, supply_5v_high};
	assign tach_cnt = '{speed_count_one, speed_count_two,
	                    speed_count_three, speed_count_four};
	assign tach_min = '{stall_limit_one, stall_limit_two,
	                    stall_limit_three, stall_limit_four};

	// Four supplies: low limit inclusive
	// Four tach channels: count above minimum means stalled
	for (genvar i = 0; i < fault_status_pkg::VOLT_CHANS; i++) begin : g_chan
		window_check #(.W(8), .SIGNED_CMP(1'b0), .LOW_INCL(1'b1)) u_volt (
			.reading    (volt_lvl[i]),
			.low_limit  (volt_lo[i]),
			.high_limit (volt_hi[i]),
			.outside    (volt_out[i])
		);
		assign stall_out[i] = tach_cnt[i] > tach_min[i];
	end

	// 12V uses a strict low bound
	window_check #(.W(8), .SIGNED_CMP(1'b0), .LOW_INCL(1'b0)) u_v12 (
		.reading    (supply_12v_level),
		.low_limit  (supply_12v_low),
		.high_limit (supply_12v_high),
		.outside    (supply_12v_flag)
	);

	// Zones compare signed so negative limits behave
	window_check #(.W(8), .SIGNED_CMP(1'b1), .LOW_INCL(1'b1)) u_zone1 (
		.reading    (diode_one_temp),
		.low_limit  (zone_one_low),
		.high_limit (zone_one_high),
		.outside    (zone_one_out)
	);
	window_check #(.W(8), .SIGNED_CMP(1'b1), .LOW_INCL(1'b1)) u_zone2 (
		.reading    (internal_temp),
		.low_limit  (zone_two_low),
		.high_limit (zone_two_high),
		.outside    (zone_two_out)
	);
	window_check #(.W(8), .SIGNED_CMP(1'b1), .LOW_INCL(1'b1)) u_zone3 (
		.reading    (diode_two_temp),
		.low_limit  (zone_three_low),
		.high_limit (zone_three_high),
		.outside    (zone_three_out)
	);

	// A broken diode reading is meaningless, so its zone flags too
	assign supply_2v5_flag         = volt_out[0];
	assign diode_one_fault_flag    = diode_one_open_short;
	assign diode_two_fault_flag    = diode_two_open_short;
	assign zone_one_limit_flag     = zone_one_out | diode_one_fault_flag;
	assign zone_two_limit_flag     = zone_two_out;
	assign zone_three_limit_flag   = zone_three_out | diode_two_fault_flag;
	assign cooler_one_stall_flag   = stall_out[0];
	assign cooler_two_stall_flag   = stall_out[1];
	assign cooler_three_stall_flag = stall_out[2];
	assign cooler_four_stall_flag  = stall_out[3];

	// Every source drives its own bit, so faults stack up together
	assign cond1 = {zone_three_limit_flag, zone_two_limit_flag, zone_one_limit_flag,
	                volt_out[3], volt_out[2], volt_out[1], supply_2v5_flag};
	assign cond2 = {diode_two_fault_flag, diode_one_fault_flag,
	                cooler_four_stall_flag, cooler_three_stall_flag,
	                cooler_two_stall_flag, cooler_one_stall_flag,
	                1'b0, supply_12v_flag};

	// ----------------------------------------------------------------
	// APB slave state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        pready_ff;
		logic        pslverr_ff;
		logic [31:0] prdata_ff;
		logic [fault_status_pkg::STS1_FLAGS-1:0] rep1_ff;
		logic [fault_status_pkg::STS2_FLAGS-1:0] rep2_ff;
	} slave_state_t;

	slave_state_t state_ff;
	slave_state_t nxt_state;
	logic [fault_status_pkg::STS1_FLAGS-1:0] sts1;
	logic [fault_status_pkg::STS2_FLAGS-1:0] sts2;
	logic [fault_status_pkg::STS1_FLAGS-1:0] clr1;
	logic [fault_status_pkg::STS2_FLAGS-1:0] clr2;
	logic [7:0]  sts1_view;
	logic        setup;
	logic        rd_done;
	logic        hit1;
	logic        hit2;

	assign setup   = psel & ~penable;
	assign rd_done = psel & penable & state_ff.pready_ff & ~pwrite;
	assign hit1    = paddr == fault_status_pkg::STS1_ADDR;
	assign hit2    = paddr == fault_status_pkg::STS2_ADDR;
	assign sts1_view = {|sts2, sts1};

	// Only the bits reported to software may be cleared
	assign clr1 = rd_done ? state_ff.rep1_ff : '0;
	assign clr2 = rd_done ? state_ff.rep2_ff : '0;

	// Answer one cycle after setup; writes store nothing
	always_comb begin
		nxt_state           = state_ff;
		nxt_state.pready_ff = 1'b0;
		if (setup) begin
			nxt_state.pready_ff  = 1'b1;
			nxt_state.pslverr_ff = ~(hit1 | hit2);
			nxt_state.prdata_ff  = 32'h0000_0000;
			nxt_state.rep1_ff    = '0;
			nxt_state.rep2_ff    = '0;
			if (!pwrite && hit1) begin
				nxt_state.prdata_ff = {24'h00_0000, sts1_view};
				nxt_state.rep1_ff   = sts1;
			end else if (!pwrite && hit2) begin
				nxt_state.prdata_ff = {24'h00_0000, sts2};
				nxt_state.rep2_ff   = sts2;
			end
		end else if (psel && penable && state_ff.pready_ff) begin
			nxt_state.rep1_ff = '0;
			nxt_state.rep2_ff = '0;
		end
	end

	// Synchronous reset of the slave
	always_ff @(posedge clock) begin
		if (!nrst) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign prdata  = state_ff.prdata_ff;
	assign pready  = state_ff.pready_ff;
	assign pslverr = state_ff.pslverr_ff;

	// ----------------------------------------------------------------
	// Sticky flags
	// ----------------------------------------------------------------
	// Writes never reach the banks, which keeps both read only
	fault_flag_bank #(.N(fault_status_pkg::STS1_FLAGS)) u_sts1 (
		.clock  (clock),
		.nrst   (nrst),
		.set_in (cond1),
		.clr_in (clr1),
		.flags  (sts1)
	);
	fault_flag_bank #(.N(fault_status_pkg::STS2_FLAGS)) u_sts2 (
		.clock  (clock),
		.nrst   (nrst),
		.set_in (cond2),
		.clr_in (clr2),
		.flags  (sts2)
	);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	chk_volt_window: assert property (
		(supply_3v3_level <= supply_3v3_low) |=> sts1[fault_status_pkg::BIT_3V3])
		else $error("3.3V flag missed at low limit");

	chk_zone_signed: assert property (
		($signed(diode_one_temp) > $signed(zone_one_high)) |=> sts1[4])
		else $error("zone one signed high missed");

	chk_zone_two: assert property (
		($signed(internal_temp) <= $signed(zone_two_low)) |=> sts1[5])
		else $error("zone two low missed");

	chk_zone_three: assert property (
		($signed(diode_two_temp) > $signed(zone_three_high)) |=> sts1[6])
		else $error("zone three high missed");

	chk_twelve_strict: assert property (
		(supply_12v_level < supply_12v_low) |=> sts2[0])
		else $error("12V low fault missed");

	chk_stall_flag: assert property (
		(speed_count_two > stall_limit_two) |=> sts2[3])
		else $error("stall flag two missed");

	chk_diode_zone: assert property (
		diode_two_open_short |=> (sts1[6] && sts2[7]))
		else $error("diode two fault not in both registers");

	chk_flag_hold: assert property (
		!rd_done |=> (($past(sts1) & ~sts1) == '0 && ($past(sts2) & ~sts2) == '0))
		else $error("flag dropped without a read");

	chk_read_clear: assert property (
		(rd_done && cond1 == '0 && cond2 == '0) |=> (sts1 & $past(clr1)) == '0
		&& (sts2 & $past(clr2)) == '0)
		else $error("read did not clear idle flags");

	chk_live_survive: assert property (
		(rd_done && cond1[0]) |=> sts1[0])
		else $error("live fault cleared by read");

	chk_write_ignored: assert property (
		(psel && penable && pwrite && cond1 == '0 && cond2 == '0)
		|=> (sts1 == $past(sts1) && sts2 == $past(sts2)))
		else $error("write changed status");

	chk_multi_fault: assert property (
		(cond1[0] && cond1[3] && cond2[0]) |=> (sts1[0] && sts1[3] && sts2[0]))
		else $error("simultaneous faults not all latched");

	chk_summary_bit: assert property (
		(setup && !pwrite && hit1) |=> (prdata[7] == ($past(sts2) != '0)))
		else $error("summary bit wrong");

	chk_reserved_zero: assert property (
		(setup && !pwrite && hit2) |=> (prdata[1] == 1'b0 && prdata[31:8] == 24'h00_0000))
		else $error("reserved bits not zero");

	chk_apb_answer: assert property (
		setup |=> (pready ##1 !pready))
		else $error("answer not one cycle after setup");

	chk_flag_one: assert property (
		(supply_5v_level > supply_5v_high) |=> sts1[3])
		else $error("5V high fault missed");

	chk_zone_one_low: assert property (
		($signed(diode_one_temp) <= $signed(zone_one_low)) |=> sts1[4])
		else $error("zone one low missed");

	chk_diode_one: assert property (
		diode_one_open_short |=> (sts2[6] && sts1[4]))
		else $error("diode one fault missed");
endmodule
`default_nettype wire

// ---- rtl/fault_status_pkg.sv ----
/*
 * Constants shared by the fault-status latch: register indices,
 * APB byte addresses, flag bit positions and reset values.
 * Assumes an APB slave with 32-bit data and a 12-bit byte address.
 */
package fault_status_pkg;
	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int          ADDR_W       = 12;
	localparam logic [7:0]  STS1_INDEX   = 8'h41;
	localparam logic [7:0]  STS2_INDEX   = 8'h42;
	localparam logic [11:0] STS1_ADDR    = {2'h0, STS1_INDEX, 2'h0};
	localparam logic [11:0] STS2_ADDR    = {2'h0, STS2_INDEX, 2'h0};
	localparam logic [7:0]  STS1_RESET   = 8'h00;
	localparam logic [7:0]  STS2_RESET   = 8'h00;

	// ----------------------------------------------------------------
	// First status register fields
	// ----------------------------------------------------------------
	localparam int BIT_2V5     = 0;
	localparam int BIT_CORE    = 1;
	localparam int BIT_3V3     = 2;
	localparam int BIT_5V      = 3;
	localparam int BIT_ZONE1   = 4;
	localparam int BIT_ZONE2   = 5;
	localparam int BIT_ZONE3   = 6;
	localparam int BIT_SUMMARY = 7;
	localparam int STS1_FLAGS  = 7;

	// ----------------------------------------------------------------
	// Second status register fields
	// ----------------------------------------------------------------
	localparam int BIT_12V      = 0;
	localparam int BIT_RESERVED = 1;
	localparam int BIT_STALL0   = 2;
	localparam int BIT_DIODE1   = 6;
	localparam int BIT_DIODE2   = 7;
	localparam int STS2_FLAGS   = 8;
	localparam int COOLERS      = 4;
	localparam int TACH_W       = 16;
	localparam int VOLT_CHANS   = 4;
endpackage

// ---- rtl/window_check.sv ----
/*
 * Window comparator: flags a reading outside its low/high limits.
 * Assumes reading and limits are stable, synchronous values.
 */
`timescale 1ns/100ps
`default_nettype none
module window_check #(
	parameter int W          = 8,
	parameter bit SIGNED_CMP = 1'b0,
	parameter bit LOW_INCL   = 1'b1
) (
	input  wire logic [W-1:0] reading,
	input  wire logic [W-1:0] low_limit,
	input  wire logic [W-1:0] high_limit,
	output logic              outside
);
	logic below;
	logic above;

	// Signed mode serves two's complement temperatures
	always_comb begin
		if (SIGNED_CMP) begin
			below = LOW_INCL ? ($signed(reading) <= $signed(low_limit))
			                 : ($signed(reading) <  $signed(low_limit));
			above = $signed(reading) > $signed(high_limit);
		end else begin
			below = LOW_INCL ? (reading <= low_limit) : (reading < low_limit);
			above = reading > high_limit;
		end
		outside = below | above;
	end
endmodule
`default_nettype wire

// ---- rtl/fault_flag_bank.sv ----
/*
 * Bank of sticky fault flags with per-bit clear.
 * Assumes set and clear pulses come from the clock domain of clock.
 */
`timescale 1ns/100ps
`default_nettype none
module fault_flag_bank #(
	parameter int N = 8
) (
	input  wire logic         clock,
	input  wire logic         nrst,
	input  wire logic [N-1:0] set_in,
	input  wire logic [N-1:0] clr_in,
	output logic      [N-1:0] flags
);
	typedef struct packed {
		logic [N-1:0] flags_ff;
	} bank_state_t;

	bank_state_t state_ff;
	bank_state_t nxt_state;

	// Set wins over clear, so a live fault survives its own read
	always_comb begin
		nxt_state          = state_ff;
		nxt_state.flags_ff = set_in | (state_ff.flags_ff & ~clr_in);
	end

	// Flags start clear
	always_ff @(posedge clock) begin
		if (!nrst) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign flags = state_ff.flags_ff;
endmodule
`default_nettype wire

// ---- verif/monitor_fault_status_latch_tb.sv ----
/*
 * Self-checking bench for the fault-status latch: APB read and write tasks,
 * stimulus on supply readings, temperatures, tach counts and diode faults.
 * Assumes the APB slave answers within a few cycles and flags show one
 * cycle after their cause.
 */
`timescale 1ns/100ps
`default_nettype none
module monitor_fault_status_latch_tb;
	// ------------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------------
	localparam logic [11:0] R1 = fault_status_pkg::STS1_ADDR;
	localparam logic [11:0] R2 = fault_status_pkg::STS2_ADDR;
	logic        clock;
	logic        nrst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [7:0]  v_lvl[5];
	logic [7:0]  v_lo[5];
	logic [7:0]  v_hi[5];
	logic [7:0]  t_val[3];
	logic [7:0]  t_lo[3];
	logic [7:0]  t_hi[3];
	logic [15:0] cnt[4];
	logic [15:0] lim[4];
	logic [1:0]  dfault;
	int          fail_count;
	int          check_count;

	// Index 0-3 are register one supplies, index 4 is the 12V input
	monitor_fault_status_latch i_monitor_fault_status_latch (
		.clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.supply_2v5_level(v_lvl[0]), .supply_2v5_low(v_lo[0]), .supply_2v5_high(v_hi[0]),
		.processor_core_supply(v_lvl[1]), .processor_core_low(v_lo[1]),
		.processor_core_high(v_hi[1]),
		.supply_3v3_level(v_lvl[2]), .supply_3v3_low(v_lo[2]), .supply_3v3_high(v_hi[2]),
		.supply_5v_level(v_lvl[3]), .supply_5v_low(v_lo[3]), .supply_5v_high(v_hi[3]),
		.supply_12v_level(v_lvl[4]), .supply_12v_low(v_lo[4]), .supply_12v_high(v_hi[4]),
		.diode_one_temp(t_val[0]), .internal_temp(t_val[1]), .diode_two_temp(t_val[2]),
		.zone_one_low(t_lo[0]), .zone_one_high(t_hi[0]), .zone_two_low(t_lo[1]),
		.zone_two_high(t_hi[1]), .zone_three_low(t_lo[2]), .zone_three_high(t_hi[2]),
		.diode_one_open_short(dfault[0]), .diode_two_open_short(dfault[1]),
		.speed_count_one(cnt[0]), .speed_count_two(cnt[1]), .speed_count_three(cnt[2]),
		.speed_count_four(cnt[3]), .stall_limit_one(lim[0]), .stall_limit_two(lim[1]),
		.stall_limit_three(lim[2]), .stall_limit_four(lim[3])
	);

	// ------------------------------------------------------------------
	// Clock and watchdog
	// ------------------------------------------------------------------
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// The whole run needs about 400 cycles; 6000 leaves ample margin
	initial begin
		repeat (6000) @(posedge clock);
		fail_count++;
		complete_run();
	end

	// ------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// One APB transfer; request held until pready is seen high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
			output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		@(posedge clock);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 40);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		chk("pready", 32'h1, {31'h0, pready});
	endtask

	task automatic rd(input logic [11:0] a, input logic [7:0] exp, input logic e_exp);
		logic [31:0] d;
		logic        e;
		apb(1'b0, a, 32'h0, d, e);
		chk("read data", {24'h0, exp}, d);
		chk("read error", {31'h0, e_exp}, {31'h0, e});
	endtask

	task automatic wr(input logic [11:0] a, input logic e_exp);
		logic [31:0] d;
		logic        e;
		apb(1'b1, a, 32'hFFFFFFFF, d, e);
		chk("write error", {31'h0, e_exp}, {31'h0, e});
	endtask

	// Flags show one cycle after their cause; two cycles is safe
	task automatic settle();
		repeat (2) @(posedge clock);
	endtask

	task automatic end_test(input string nm);
		$display("test %s done", nm);
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		int         i;
		logic [7:0] m;
		fail_count = 0;
		check_count = 0;
		nrst = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		dfault = 2'h0;
		// Safe levels; 0xF6 is -10 C, flagged only by an unsigned compare
		for (i = 0; i < 5; i++) begin
			v_lvl[i] = 8'h80;
			v_lo[i] = 8'h10;
			v_hi[i] = 8'hF0;
		end
		for (i = 0; i < 3; i++) begin
			t_val[i] = 8'hF6;
			t_lo[i] = (i == 1) ? 8'hE0 : 8'hEC;
			t_hi[i] = 8'h14;
		end
		for (i = 0; i < 4; i++) begin
			cnt[i] = 16'h0100;
			lim[i] = 16'h1000;
		end
		repeat (10) @(posedge clock);
		nrst <= 1'b1;
		rd(R1, 8'h00, 1'b0);
		rd(R2, 8'h00, 1'b0);
		end_test("reset");

		// Supply windows: low inclusive, high exclusive, sticky then cleared
		for (i = 0; i < 4; i++) begin
			m = 8'(1 << i);
			@(posedge clock);
			v_lvl[i] <= 8'h10;
			settle();
			rd(R1, m, 1'b0);
			rd(R1, m, 1'b0);
			@(posedge clock);
			v_lvl[i] <= 8'hF0;
			settle();
			rd(R1, m, 1'b0);
			rd(R1, 8'h00, 1'b0);
			@(posedge clock);
			v_lvl[i] <= 8'hF1;
			settle();
			@(posedge clock);
			v_lvl[i] <= 8'h80;
			settle();
			rd(R1, m, 1'b0);
			rd(R1, 8'h00, 1'b0);
		end
		end_test("supplies");

		// 12V strict window and summary bit
		@(posedge clock);
		v_lvl[4] <= 8'h10;
		settle();
		rd(R2, 8'h00, 1'b0);
		@(posedge clock);
		v_lvl[4] <= 8'hF0;
		settle();
		rd(R2, 8'h00, 1'b0);
		@(posedge clock);
		v_lvl[4] <= 8'h0F;
		settle();
		@(posedge clock);
		v_lvl[4] <= 8'h80;
		settle();
		rd(R1, 8'h80, 1'b0);
		rd(R2, 8'h01, 1'b0);
		rd(R1, 8'h00, 1'b0);
		end_test("twelve volt");

		// Signed zone windows; zone two uses its own low limit
		for (i = 0; i < 3; i++) begin
			m = 8'(8'h10 << i);
			@(posedge clock);
			t_val[i] <= t_lo[i];
			settle();
			@(posedge clock);
			t_val[i] <= 8'h14;
			settle();
			rd(R1, m, 1'b0);
			rd(R1, 8'h00, 1'b0);
			@(posedge clock);
			t_val[i] <= 8'h15;
			settle();
			@(posedge clock);
			t_val[i] <= 8'hF6;
			settle();
			rd(R1, m, 1'b0);
			rd(R1, 8'h00, 1'b0);
		end
		end_test("zones");

		// Stall flags: count equal to minimum is fine, one above stalls
		for (i = 0; i < 4; i++) begin
			@(posedge clock);
			cnt[i] <= 16'h1000;
			settle();
			rd(R2, 8'h00, 1'b0);
			@(posedge clock);
			cnt[i] <= 16'h1001;
			settle();
			@(posedge clock);
			cnt[i] <= 16'h0100;
			settle();
			rd(R2, 8'(8'h04 << i), 1'b0);
			rd(R2, 8'h00, 1'b0);
		end
		end_test("stalls");

		// Diode faults set their own flag and the matching zone flag
		for (i = 0; i < 2; i++) begin
			m = 8'(8'h10 << (2 * i));
			@(posedge clock);
			dfault[i] <= 1'b1;
			settle();
			rd(R2, 8'(8'h40 << i), 1'b0);
			rd(R1, m | 8'h80, 1'b0);
			@(posedge clock);
			dfault[i] <= 1'b0;
			settle();
			rd(R2, 8'(8'h40 << i), 1'b0);
			rd(R2, 8'h00, 1'b0);
			rd(R1, m, 1'b0);
			rd(R1, 8'h00, 1'b0);
		end
		end_test("diodes");

		// Several faults in one read, then writes that change nothing
		@(posedge clock);
		v_lvl[0] <= 8'h10;
		v_lvl[3] <= 8'hFF;
		v_lvl[4] <= 8'h0F;
		cnt[0] <= 16'hFFFF;
		settle();
		@(posedge clock);
		v_lvl[0] <= 8'h80;
		v_lvl[3] <= 8'h80;
		v_lvl[4] <= 8'h80;
		cnt[0] <= 16'h0100;
		settle();
		wr(R1, 1'b0);
		wr(R2, 1'b0);
		rd(R1, 8'h89, 1'b0);
		rd(R2, 8'h05, 1'b0);
		rd(R1, 8'h00, 1'b0);
		wr(12'h10C, 1'b1);
		rd(12'h10C, 8'h00, 1'b1);
		end_test("multiple and writes");
		complete_run();
	end
endmodule
`default_nettype wire
